/* common/rcpoc_pkg.sv */
// constants shared by the reset-cause and power-on-clear block
package rcpoc_pkg;
  // register address
  localparam logic [19:0] RESET_CAUSE_ADDR   = 20'hfffa8;
  // cause bit positions
  localparam int          TRAP_BIT           = 7;
  localparam int          WDOG_BIT           = 4;
  localparam int          LVOLT_BIT          = 0;
  // reset values
  localparam logic [7:0]  CAUSE_RST          = 8'h00;
  localparam logic [7:0]  LVL_SEL_RST        = 8'h0e;
  localparam logic [7:0]  LVCTL_RST          = 8'h00;
  // control value when the detector is started by default: reset mode bit 1
  localparam logic [7:0]  LVCTL_DEFON        = 8'h82;
  localparam logic [7:0]  ILLEGAL_OPCODE     = 8'hff;
endpackage : rcpoc_pkg

/* rtl/rcpoc_top.sv */
// reset-cause capture and power-on-clear reset control
`timescale 1ns/10ps
module rcpoc_top (
  // clock, reset, enable
  input  wire logic        MCLK,
  input  wire logic        RST_N,
  input  wire logic        CLK_EN,
  // reset sources (pins and analog comparators, asynchronous)
  input  wire logic        RESET_PIN_N,
  input  wire logic        SUPPLY_RISE_OK,
  input  wire logic        SUPPLY_FALL_LOW,
  input  wire logic        LOWVOLT_BELOW,
  // reset sources from same-clock logic
  input  wire logic        WATCHDOG_TIMER_RST,
  input  wire logic        OPCODE_VALID,
  input  wire logic [7:0]  OPCODE,
  // option byte, lowvolt_default_disable
  input  wire logic        LOWVOLT_DEFAULT_DISABLE,
  // register port
  input  wire logic [19:0] REG_ADDR,
  input  wire logic        REG_RD,
  input  wire logic        REG_WR,
  input  wire logic [7:0]  REG_WDATA,
  input  wire logic        LVL_SEL_WR,
  input  wire logic        LVCTL_WR,
  output logic      [7:0]  REG_RDATA,
  // state out
  output logic             INT_RESET,
  output logic      [7:0]  LOWVOLT_LEVEL_SELECT,
  output logic      [7:0]  LOWVOLT_DETECT_CONTROL
);

  typedef enum logic [1:0] {
    RCPOC_ST_POWERUP = 2'b00,
    RCPOC_ST_RUN     = 2'b01,
    RCPOC_ST_RESET   = 2'b10
  } rcpoc_state_t;

  // three-stage synchronisers for the asynchronous inputs
  logic [2:0] s_pin_r, s_rise_r, s_fall_r, s_lv_r;
  logic [2:0] s_pin_nxt, s_rise_nxt, s_fall_nxt, s_lv_nxt;
  logic       pin_q_r, rise_q_r, fall_q_r, lv_q_r;
  logic       pin_q_nxt, rise_q_nxt, fall_q_nxt, lv_q_nxt;

  // filtered value follows only when stages two and three agree
  function automatic logic agree(input logic [2:0] s, input logic q);
    agree = (s[1] == s[2]) ? s[2] : q;
  endfunction : agree

  always_comb begin
    s_pin_nxt  = {s_pin_r[1:0], RESET_PIN_N};
    s_rise_nxt = {s_rise_r[1:0], SUPPLY_RISE_OK};
    s_fall_nxt = {s_fall_r[1:0], SUPPLY_FALL_LOW};
    s_lv_nxt   = {s_lv_r[1:0], LOWVOLT_BELOW};
    pin_q_nxt  = agree(s_pin_r, pin_q_r);
    rise_q_nxt = agree(s_rise_r, rise_q_r);
    fall_q_nxt = agree(s_fall_r, fall_q_r);
    lv_q_nxt   = agree(s_lv_r, lv_q_r);
  end

  // safe constants at reset: pin released, supply low, below threshold
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      s_pin_r  <= 3'h7;
      s_rise_r <= 3'h0;
      s_fall_r <= 3'h7;
      s_lv_r   <= 3'h7;
      pin_q_r  <= 1'b1;
      rise_q_r <= 1'b0;
      fall_q_r <= 1'b1;
      lv_q_r   <= 1'b1;
    end else if (CLK_EN) begin
      s_pin_r  <= s_pin_nxt;
      s_rise_r <= s_rise_nxt;
      s_fall_r <= s_fall_nxt;
      s_lv_r   <= s_lv_nxt;
      pin_q_r  <= pin_q_nxt;
      rise_q_r <= rise_q_nxt;
      fall_q_r <= fall_q_nxt;
      lv_q_r   <= lv_q_nxt;
    end
  end

  // reset requests
  logic req_pin, req_poc, req_trap, req_wdog, req_lv, req_any, lv_rst_en;
  assign lv_rst_en = LOWVOLTAGE_RESET_MODE(LOWVOLT_DETECT_CONTROL);
  assign req_pin   = !pin_q_r;
  // power-on-clear: supply not yet risen, or fallen below threshold
  assign req_poc   = !rise_q_r || fall_q_r;
  assign req_trap  = OPCODE_VALID && (OPCODE == rcpoc_pkg::ILLEGAL_OPCODE);
  assign req_wdog  = WATCHDOG_TIMER_RST;
  assign req_lv    = lv_q_r && lv_rst_en;
  assign req_any   = req_pin || req_poc || req_trap || req_wdog || req_lv;

  // control bit 1 selects reset mode, bit 7 enables the detector
  function automatic logic LOWVOLTAGE_RESET_MODE(input logic [7:0] c);
    LOWVOLTAGE_RESET_MODE = c[7] && c[1];
  endfunction : LOWVOLTAGE_RESET_MODE

  rcpoc_state_t state_r, state_nxt;
  logic [7:0]   cause_r, cause_nxt;
  logic [7:0]   lvsel_r, lvsel_nxt;
  logic [7:0]   lvctl_r, lvctl_nxt;
  logic [7:0]   rdata_r, rdata_nxt;
  logic         irst_r, irst_nxt;
  logic         cause_rd;

  assign cause_rd = REG_RD && (REG_ADDR == rcpoc_pkg::RESET_CAUSE_ADDR);

  // request groups shared by several registers
  logic cause_take;
  logic req_clear;
  logic req_reinit;
  logic reg_open;

  // only bits with a source can ever hold a one
  localparam logic [7:0] CAUSE_MASK = (8'h01 << rcpoc_pkg::TRAP_BIT) |
                                      (8'h01 << rcpoc_pkg::WDOG_BIT) |
                                      (8'h01 << rcpoc_pkg::LVOLT_BIT);

  // a read counts only while the core runs; reads in reset are dropped
  assign cause_take = cause_rd && (state_r == RCPOC_ST_RUN);
  // pin and power-on-clear wipe the whole cause register
  assign req_clear  = req_pin || req_poc;
  // every source but the detector reloads its settings
  assign req_reinit = req_clear || req_trap || req_wdog;
  // register writes land only in the run state with no request pending
  assign reg_open   = (state_r == RCPOC_ST_RUN) && !req_any;

  // sequencer next state: power-up hold, run, reset while a request stands
  always_comb begin
    state_nxt = state_r;
    irst_nxt  = irst_r;
    unique case (state_r)
      RCPOC_ST_POWERUP: begin
        // held until the pin is released and the supply and, if default-on, the comparator are good
        irst_nxt = 1'b1;
        if (!req_poc && !req_pin &&
            (LOWVOLT_DEFAULT_DISABLE || !lv_q_r)) begin
          state_nxt = RCPOC_ST_RUN;
          irst_nxt  = 1'b0;
        end
      end
      RCPOC_ST_RUN: begin
        // even a one-cycle pulse from the watchdog or decode enters reset
        if (req_any) begin
          state_nxt = RCPOC_ST_RESET;
          irst_nxt  = 1'b1;
        end
      end
      RCPOC_ST_RESET: begin
        // internal reset stays high and register writes are blocked while the request stands
        irst_nxt = 1'b1;
        if (!req_any) begin
          state_nxt = RCPOC_ST_RUN;
          irst_nxt  = 1'b0;
        end
      end
      default: begin
        // the fourth code is unused; recover through the power-up hold
        state_nxt = RCPOC_ST_POWERUP;
        irst_nxt  = 1'b1;
      end
    endcase
  end

  // sequencer registers; internal reset stays high from power-up
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      state_r <= RCPOC_ST_POWERUP;
      irst_r  <= 1'b1;
    end else if (CLK_EN) begin
      state_r <= state_nxt;
      irst_r  <= irst_nxt;
    end
  end

  // cause flags: a read clears, but a set in the same cycle wins
  always_comb begin
    cause_nxt = cause_r;
    if (cause_take) begin
      cause_nxt = rcpoc_pkg::CAUSE_RST;
    end
    if (req_clear) begin
      // pin and power-on-clear win over every other source
      cause_nxt = rcpoc_pkg::CAUSE_RST;
    end else begin
      // several sources in one cycle each leave their own flag
      if (req_trap) begin
        cause_nxt[rcpoc_pkg::TRAP_BIT] = 1'b1;
      end
      if (req_wdog) begin
        cause_nxt[rcpoc_pkg::WDOG_BIT] = 1'b1;
      end
      if (req_lv) begin
        // a default-on detector can set this before power-up ends
        cause_nxt[rcpoc_pkg::LVOLT_BIT] = 1'b1;
      end
    end
    // no write path exists, so software cannot forge a cause
    cause_nxt = cause_nxt & CAUSE_MASK;
  end

  // cause register
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      cause_r <= rcpoc_pkg::CAUSE_RST;
    end else if (CLK_EN) begin
      cause_r <= cause_nxt;
    end
  end

  // level select: reloaded by all sources except the detector itself
  always_comb begin
    lvsel_nxt = lvsel_r;
    if (req_reinit) begin
      lvsel_nxt = rcpoc_pkg::LVL_SEL_RST;
    end else if (reg_open && REG_WR && LVL_SEL_WR) begin
      lvsel_nxt = REG_WDATA;
    end
  end

  // level select register
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      lvsel_r <= rcpoc_pkg::LVL_SEL_RST;
    end else if (CLK_EN) begin
      lvsel_r <= lvsel_nxt;
    end
  end

  // detect control: the detector keeps running across its own reset,
  // so only the other sources reload it, from the option bit
  always_comb begin
    lvctl_nxt = lvctl_r;
    if (req_reinit) begin
      if (LOWVOLT_DEFAULT_DISABLE) begin
        lvctl_nxt = rcpoc_pkg::LVCTL_RST;
      end else begin
        lvctl_nxt = rcpoc_pkg::LVCTL_DEFON;
      end
    end else if (reg_open && REG_WR && LVCTL_WR) begin
      lvctl_nxt = REG_WDATA;
    end
  end

  // detect control register
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      lvctl_r <= rcpoc_pkg::LVCTL_RST;
    end else if (CLK_EN) begin
      lvctl_r <= lvctl_nxt;
    end
  end

  // read data stands one cycle; idle cycles return zero so a stray
  // sample never shows a stale cause
  always_comb begin
    rdata_nxt = rcpoc_pkg::CAUSE_RST;
    if (cause_take) begin
      rdata_nxt = cause_r;
    end
  end

  // read data register
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_r <= rcpoc_pkg::CAUSE_RST;
    end else if (CLK_EN) begin
      rdata_r <= rdata_nxt;
    end
  end

  // outputs come straight from the registers above
  assign REG_RDATA              = rdata_r;
  assign INT_RESET              = irst_r;
  assign LOWVOLT_LEVEL_SELECT   = lvsel_r;
  assign LOWVOLT_DETECT_CONTROL = lvctl_r;

endmodule : rcpoc_top

/* testbench/rcpoc_chk.sv */
// assertion checker for the reset-cause block
`timescale 1ns/10ps
module rcpoc_chk (
  // clock and reset
  input wire logic        MCLK,
  input wire logic        RST_N,
  input wire logic        CLK_EN,
  // reset sources
  input wire logic        RESET_PIN_N,
  input wire logic        SUPPLY_RISE_OK,
  input wire logic        SUPPLY_FALL_LOW,
  input wire logic        WATCHDOG_TIMER_RST,
  input wire logic        OPCODE_VALID,
  input wire logic [7:0]  OPCODE,
  // register port and state
  input wire logic [19:0] REG_ADDR,
  input wire logic        REG_RD,
  input wire logic [7:0]  REG_RDATA,
  input wire logic        INT_RESET,
  input wire logic [7:0]  LOWVOLT_LEVEL_SELECT
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  // run state, taken read and illegal opcode
  wire run  = CLK_EN && !INT_RESET;
  wire take = run && REG_RD && REG_ADDR == rcpoc_pkg::RESET_CAUSE_ADDR;
  wire trap = OPCODE_VALID && OPCODE == rcpoc_pkg::ILLEGAL_OPCODE;
  chk_rdata_cause: assert property (
    REG_RDATA != 8'h00 |-> $past(take)) else $error("stray read data");
  chk_rsvd_zero: assert property (
    (REG_RDATA & 8'h6e) == 8'h00) else $error("reserved bit set");
  chk_read_clears: assert property (
    take ##1 run ##1 take |=> REG_RDATA == 8'h00) else $error("not cleared");
  chk_pin_reset: assert property (
    !RESET_PIN_N [*6] |-> INT_RESET) else $error("pin reset missed");
  chk_fall_reset: assert property (
    SUPPLY_FALL_LOW [*6] |-> INT_RESET) else $error("fall reset missed");
  chk_release_ok: assert property (
    $fell(INT_RESET) |-> $past(SUPPLY_RISE_OK, 2) && $past(RESET_PIN_N, 2))
    else $error("early release");
  chk_wdog_reset: assert property (
    run && WATCHDOG_TIMER_RST |=> INT_RESET) else $error("watchdog missed");
  chk_trap_reset: assert property (
    run && trap |=> INT_RESET) else $error("illegal opcode missed");
  chk_lvsel_init: assert property (
    run && WATCHDOG_TIMER_RST |=> LOWVOLT_LEVEL_SELECT == 8'h0e)
    else $error("level select not reinitialised");
  // main scenarios
  cover property (take ##1 REG_RDATA == 8'h90);
  cover property ($fell(INT_RESET));
  cover property (take ##1 REG_RDATA == 8'h01);
endmodule : rcpoc_chk

/* testbench/rcpoc_src_model.sv */
// reset-source model: watchdog, cpu decode, comparators and pin
`timescale 1ns/10ps
module rcpoc_src_model (
  // clock and request from the bench
  input  wire logic       clk,
  input  wire logic [4:0] kick,
  // reset sources
  output logic            wd_rst,
  output logic            op_vld,
  output logic [7:0]      op,
  output logic            lv_below,
  output logic            fall_low,
  output logic            pin_n
);
  logic [2:0] hold;
  logic [2:0] which;
  logic [4:0] k;
  // slow sources stay active six cycles so the synchronisers catch them;
  // the request is taken at the edge, before the bench changes it
  always @(posedge clk) begin
    k = kick;
    #1;
    wd_rst = k[0];
    op_vld = k[1];
    op = k[1] ? 8'hff : ~op; // idle opcode bus keeps toggling
    if (k[4:2] != 3'h0) begin
      which = k[4:2];
      hold = 3'h6;
    end else if (hold != 3'h0) begin
      hold = hold - 3'h1;
    end
    lv_below = (hold != 3'h0) && which[0];
    fall_low = (hold != 3'h0) && which[1];
    pin_n = !((hold != 3'h0) && which[2]);
  end
  // quiet sources at power-up
  initial begin
    {wd_rst, op_vld, lv_below, fall_low, hold, which} = 10'h0;
    op = 8'h5a;
    pin_n = 1'b1;
  end
endmodule : rcpoc_src_model

/* testbench/reset_cause_and_poc_control_bench.sv */
// self-checking bench for the reset-cause block
`timescale 1ns/10ps
module reset_cause_and_poc_control_bench;
  logic MCLK = 1'b0, RST_N = 1'b0, CLK_EN = 1'b1, SUPPLY_RISE_OK = 1'b1;
  logic LOWVOLT_DEFAULT_DISABLE = 1'b1, REG_RD = 1'b0, REG_WR = 1'b0;
  logic LVL_SEL_WR = 1'b0, LVCTL_WR = 1'b0;
  logic [19:0] REG_ADDR = 20'h0;
  logic [7:0] REG_WDATA = 8'h00;
  logic [4:0] kick = 5'h00;
  logic RESET_PIN_N, SUPPLY_FALL_LOW, LOWVOLT_BELOW, WATCHDOG_TIMER_RST;
  logic OPCODE_VALID, INT_RESET;
  logic [7:0] OPCODE, REG_RDATA, LOWVOLT_LEVEL_SELECT, LOWVOLT_DETECT_CONTROL;
  int n_mismatch = 0, checks = 0;
  always #2 MCLK = ~MCLK;
  rcpoc_top dut (.MCLK, .RST_N, .CLK_EN, .RESET_PIN_N, .SUPPLY_RISE_OK,
    .SUPPLY_FALL_LOW, .LOWVOLT_BELOW, .WATCHDOG_TIMER_RST, .OPCODE_VALID,
    .OPCODE, .LOWVOLT_DEFAULT_DISABLE, .REG_ADDR, .REG_RD, .REG_WR,
    .REG_WDATA, .LVL_SEL_WR, .LVCTL_WR, .REG_RDATA, .INT_RESET,
    .LOWVOLT_LEVEL_SELECT, .LOWVOLT_DETECT_CONTROL);
  rcpoc_src_model u_src (.clk(MCLK), .kick(kick), .wd_rst(WATCHDOG_TIMER_RST),
    .op_vld(OPCODE_VALID), .op(OPCODE), .lv_below(LOWVOLT_BELOW),
    .fall_low(SUPPLY_FALL_LOW), .pin_n(RESET_PIN_N));
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  task automatic cmp(input logic [7:0] got, exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  // inputs change one step after the rising edge
  task automatic tick;
    @(posedge MCLK);
    #1;
  endtask : tick
  task automatic wait_lvl(input logic v);
    for (int i = 0; i < 40 && INT_RESET !== v; i++) tick;
    cmp({7'h0, INT_RESET}, {7'h0, v});
  endtask : wait_lvl
  // one cause read, data due one cycle later
  task automatic rd_c(input logic [7:0] exp);
    tick;
    REG_RD = 1'b1;
    REG_ADDR = rcpoc_pkg::RESET_CAUSE_ADDR;
    tick;
    REG_RD = 1'b0;
    cmp(REG_RDATA, exp);
  endtask : rd_c
  task automatic wr(input logic [1:0] sel, input logic [7:0] d);
    tick;
    {REG_WR, LVCTL_WR, LVL_SEL_WR, REG_WDATA} = {1'b1, sel, d};
    REG_ADDR = (sel == 2'b00) ? rcpoc_pkg::RESET_CAUSE_ADDR : 20'h0;
    tick;
    {REG_WR, LVCTL_WR, LVL_SEL_WR} = 3'b000;
  endtask : wr
  task automatic fire(input logic [4:0] k);
    tick;
    kick = k;
    tick;
    kick = 5'h00;
    wait_lvl(1'b1);
    wait_lvl(1'b0);
  endtask : fire
  // main sequence
  initial begin
    repeat (12) @(posedge MCLK);
    #1 RST_N = 1'b1;
    wait_lvl(1'b0);
    cmp(LOWVOLT_LEVEL_SELECT, rcpoc_pkg::LVL_SEL_RST);
    cmp(LOWVOLT_DETECT_CONTROL, rcpoc_pkg::LVCTL_RST);
    rd_c(8'h00);
    wr(2'b00, 8'hff);
    rd_c(8'h00);
    wr(2'b01, 8'h05);
    fire(5'h01);
    cmp(LOWVOLT_LEVEL_SELECT, 8'h0e);
    rd_c(8'h10);
    rd_c(8'h00);
    fire(5'h02);
    fire(5'h01);
    rd_c(8'h90);
    fire(5'h03);
    rd_c(8'h90);
    wr(2'b10, 8'h82);
    wr(2'b01, 8'h05);
    fire(5'h04);
    cmp(LOWVOLT_LEVEL_SELECT, 8'h05);
    rd_c(8'h01);
    fire(5'h02);
    fire(5'h08);
    rd_c(8'h00);
    fire(5'h02);
    fire(5'h10);
    rd_c(8'h00);
    // power-up with the detector on by default and supply still low
    {LOWVOLT_DEFAULT_DISABLE, SUPPLY_RISE_OK, RST_N} = 3'b000;
    tick;
    {RST_N, kick} = {1'b1, 5'h04};
    tick;
    {SUPPLY_RISE_OK, kick} = {1'b1, 5'h00};
    repeat (4) tick;
    cmp({7'h0, INT_RESET}, 8'h01);
    wait_lvl(1'b0);
    cmp(LOWVOLT_DETECT_CONTROL, rcpoc_pkg::LVCTL_DEFON);
    rd_c(8'h01);
    rd_c(8'h00);
    report_and_stop;
  end
  // hang guard, far beyond the expected run
  initial begin
    repeat (4000) @(posedge MCLK);
    n_mismatch++;
    report_and_stop;
  end
endmodule : reset_cause_and_poc_control_bench
bind rcpoc_top rcpoc_chk u_chk (.MCLK, .RST_N, .CLK_EN, .RESET_PIN_N,
  .SUPPLY_RISE_OK, .SUPPLY_FALL_LOW, .WATCHDOG_TIMER_RST, .OPCODE_VALID,
  .OPCODE, .REG_ADDR, .REG_RD, .REG_RDATA, .INT_RESET, .LOWVOLT_LEVEL_SELECT);
